// file: hdl/scq_top.sv
`timescale 1ns/1ps
module scq_top import scq_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int NPORT = 11,
  parameter int HO_CYCLES = HO_ACQ_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NPORT-1:0] port_rec_clk,
  input wire logic [1:0] diff_clk_in,
  input wire logic [3:0] gpio_clk_in,
  input wire logic [1:0] xg_rec_clk,
  input wire logic [3:0] los_in,
  input wire logic [3:0] lol_in,
  output logic general_alarm,
  output logic [1:0] selected_input,
  output logic [1:0] ctrl_state,
  output logic [31:0] freq_word
);
  localparam int NSRC = NPORT + 6;

  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n, logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[8*b +: 8] = n[8*b +: 8];
    end
    return r;
  endfunction

  // ==========================================================
  // Register storage
  logic [31:0] cfg_mem [NQUAL][NCFG];
  logic [2:0] sticky [NQUAL];
  logic [31:0] ctrl;
  logic [31:0] free_off;

  // Qualifier outputs
  logic [5:0] alarm [NQUAL];
  logic [2:0] err_pulse [NQUAL];
  logic [15:0] filt [NQUAL];
  logic [NQUAL-1:0] clkctl_al;
  logic [NQUAL-1:0] gen_al;

  // ==========================================================
  // Write channel: address and data are caught in either order
  logic aw_held, w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  assign s_axi_awready = ~aw_held;
  assign s_axi_wready = ~w_held;

  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire [7:0] wa = 8'(aw_addr);
  wire w_in_qual = ~wa[7];
  wire [1:0] w_q = wa[6:5];
  wire [2:0] w_word = wa[4:2];
  wire w_cfg = w_in_qual & (w_word < 3'(NCFG));
  wire w_stat = w_in_qual & ({3'd0, wa[4:0]} == OFF_STAT);
  wire w_ctrl = (wa == OFF_CTRL);
  wire w_free = (wa == OFF_FREE_OFFSET);
  wire w_ro = (wa == OFF_CTRL_STAT) | (wa == OFF_FILT_FREQ);
  wire w_ok = (w_cfg | w_stat | w_ctrl | w_free | w_ro) & (wa[1:0] == 2'b00);

  // Channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid & ~aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Global registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RST;
      free_off <= 32'h0000_0000;
    end else if (do_write & w_ok) begin
      if (w_ctrl) ctrl <= merge(ctrl, w_data, w_strb);
      if (w_free) free_off <= merge(free_off, w_data, w_strb);
    end
  end

  // ==========================================================
  // Per-qualifier registers, source selection and collectors
  for (genvar q = 0; q < NQUAL; q++) begin : g_q
    wire scq_qcfg_type qcfg = scq_qcfg_type'({cfg_mem[q][4], cfg_mem[q][3], cfg_mem[q][2],
                                            cfg_mem[q][1], cfg_mem[q][0]});
    wire hit = do_write & w_ok & (w_q == 2'(q));
    wire [2:0] clr = (hit & w_stat & w_strb[0]) ? w_data[2:0] : 3'b000;
    logic clk_src;

    // Only the first two qualifiers have a source mux; the others are wired
    if (q < 2) begin : g_mux
      wire [NSRC-1:0] all_src = {gpio_clk_in, diff_clk_in, port_rec_clk};
      assign clk_src = (int'(qcfg.src_sel) < NSRC) ? all_src[qcfg.src_sel] : 1'b0;
    end else begin : g_fixed
      assign clk_src = xg_rec_clk[q-2];
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cfg_mem[q][0] <= CFG0_RST;
        cfg_mem[q][1] <= CFG1_RST;
        cfg_mem[q][2] <= CFG2_RST;
        cfg_mem[q][3] <= CFG3_RST;
        cfg_mem[q][4] <= CFG4_RST;
        sticky[q] <= 3'b000;
      end else begin
        if (hit & w_cfg) cfg_mem[q][w_word] <= merge(cfg_mem[q][w_word], w_data, w_strb);
        // A new error in the clearing cycle survives the clear
        sticky[q] <= (sticky[q] & ~clr) | err_pulse[q];
      end
    end

    scq_qual u_qual (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_sample(clk_src),
      .los_in(los_in[q]),
      .lol_in(lol_in[q]),
      .cfg(qcfg),
      .alarm(alarm[q]),
      .err_pulse(err_pulse[q]),
      .filt_period(filt[q])
    );

    assign clkctl_al[q] = |(alarm[q] & qcfg.clkctl_mask);
    assign gen_al[q] = |(alarm[q] & qcfg.gen_mask);
  end

  // ==========================================================
  // Read channel
  logic ho_valid;
  logic [31:0] ho_value;
  scq_state_type state;

  wire [7:0] ra = 8'(s_axi_araddr);
  wire [1:0] r_q = ra[6:5];
  wire [2:0] r_word = ra[4:2];
  wire r_in_qual = ~ra[7] & (ra[1:0] == 2'b00);
  wire r_cfg = r_in_qual & (r_word < 3'(NCFG));
  wire r_stat = r_in_qual & ({3'd0, ra[4:0]} == OFF_STAT);
  wire [31:0] stat_word = {filt[r_q], 5'd0, gen_al[r_q], clkctl_al[r_q], alarm[r_q], sticky[r_q]};
  wire [31:0] cstat_word = {20'd0, ~clkctl_al, 3'd0, ho_valid, state, selected_input};

  logic [31:0] rd_data;
  logic rd_ok;

  // Read decode; unmapped addresses answer with an error and zero data
  always_comb begin
    rd_ok = 1'b1;
    rd_data = 32'h0000_0000;
    if (r_cfg) rd_data = cfg_mem[r_q][r_word];
    else if (r_stat) rd_data = stat_word;
    else if (ra == OFF_CTRL) rd_data = ctrl;
    else if (ra == OFF_FREE_OFFSET) rd_data = free_off;
    else if (ra == OFF_CTRL_STAT) rd_data = cstat_word;
    else if (ra == OFF_FILT_FREQ) rd_data = {16'd0, filt[selected_input]};
    else rd_ok = 1'b0;
  end

  assign s_axi_arready = ~s_axi_rvalid;

  // One read at a time; data stands until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid & ~s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Equipment clock controller
  scq_mode_type mode;
  scq_state_type next_state;
  logic found;
  logic [1:0] pick;
  logic [31:0] ho_cnt;

  // Mode value 3 is unused and falls back to automatic
  always_comb begin
    case (ctrl[1:0])
      2'd1: mode = SCQ_MODE_HOLDOVER;
      2'd2: mode = SCQ_MODE_FREERUN;
      default: mode = SCQ_MODE_AUTO;
    endcase
  end

  // Priority 0 wins; scanning from the lowest priority lets higher slots overwrite
  always_comb begin
    found = 1'b0;
    pick = 2'd0;
    for (int p = NQUAL - 1; p >= 0; p--) begin
      if (ctrl[10 + p] & ~clkctl_al[ctrl[2 + 2*p +: 2]]) begin
        found = 1'b1;
        pick = ctrl[2 + 2*p +: 2];
      end
    end
  end

  // State choice; the reference switch itself is glitch-free since only the word changes
  always_comb begin
    case (mode)
      SCQ_MODE_HOLDOVER: next_state = SCQ_ST_HOLDOVER;
      SCQ_MODE_FREERUN: next_state = SCQ_ST_FREERUN;
      default: begin
        if (found) next_state = SCQ_ST_LOCKED;
        else if (ho_valid) next_state = SCQ_ST_HOLDOVER;
        else next_state = SCQ_ST_FREERUN;
      end
    endcase
  end

  // State, selection and holdover data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= SCQ_ST_FREERUN;
      selected_input <= 2'd0;
      ho_cnt <= 32'h0000_0000;
      ho_valid <= 1'b0;
      ho_value <= 32'h0000_0000;
    end else begin
      state <= next_state;
      if (mode == SCQ_MODE_AUTO && found) selected_input <= pick;
      case (state)
        SCQ_ST_LOCKED: begin
          ho_value <= {16'd0, filt[selected_input]};
          if (ho_cnt >= 32'(HO_CYCLES - 1)) ho_valid <= 1'b1;
          else ho_cnt <= ho_cnt + 32'h0000_0001;
        end
        SCQ_ST_FREERUN: begin
          // Free-run throws away gathered holdover data
          ho_cnt <= 32'h0000_0000;
          ho_valid <= 1'b0;
        end
        default: ho_cnt <= ho_cnt;
      endcase
    end
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      freq_word <= 32'h0000_0000;
      general_alarm <= 1'b0;
      ctrl_state <= 2'd0;
    end else begin
      case (state)
        SCQ_ST_LOCKED: freq_word <= {16'd0, filt[selected_input]};
        SCQ_ST_HOLDOVER: freq_word <= ho_value;
        default: freq_word <= free_off;
      endcase
      general_alarm <= |gen_al;
      ctrl_state <= state;
    end
  end

endmodule // scq_top

// file: hdl/scq_pkg.sv
package scq_pkg;
  // ==========================================================
  // Clock and register map
  localparam int CLK_FREQ_MHZ = 200;
  localparam int NQUAL = 4;
  localparam int NCFG = 5;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] OFF_CTRL = 8'h80;
  localparam logic [7:0] OFF_FREE_OFFSET = 8'h84;
  localparam logic [7:0] OFF_CTRL_STAT = 8'h88;
  localparam logic [7:0] OFF_FILT_FREQ = 8'h8c;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ==========================================================
  // Reset values
  localparam logic [31:0] CFG0_RST = 32'h0402_0032;
  localparam logic [31:0] CFG1_RST = 32'h0008_0004;
  localparam logic [31:0] CFG2_RST = 32'h3ffc_0142;
  localparam logic [31:0] CFG3_RST = 32'h1004_1004;
  localparam logic [31:0] CFG4_RST = 32'h1f00_0101;
  localparam logic [31:0] CTRL_RST = 32'h0000_3f90;

  // ==========================================================
  // Timing
  localparam logic [4:0] PFM_TC_EXTRA = 5'h04;
  localparam int HO_ACQ_TIME_MS = 1000;
  localparam int HO_ACQ_CYCLES = HO_ACQ_TIME_MS * 1000 * CLK_FREQ_MHZ;

  // ==========================================================
  // Alarm positions
  localparam int AL_SCM = 0;
  localparam int AL_CFM = 1;
  localparam int AL_PFM = 2;
  localparam int AL_LOS = 3;
  localparam int AL_LOL = 4;
  localparam int AL_GST = 5;

  typedef enum logic [1:0] {SCQ_MODE_AUTO, SCQ_MODE_HOLDOVER, SCQ_MODE_FREERUN} scq_mode_type;
  typedef enum logic [1:0] {SCQ_ST_FREERUN, SCQ_ST_LOCKED, SCQ_ST_HOLDOVER} scq_state_type;

  // Five config words per qualifier, word 4 first (MSB)
  typedef struct packed {
    logic [2:0] rsv4;
    logic [4:0] gst_en;
    logic [2:0] rsv4b;
    logic [4:0] src_sel;
    logic [7:0] incr_q;
    logic [7:0] incr_d;
    logic [7:0] thr_q;
    logic [7:0] prediv_q;
    logic [7:0] thr_d;
    logic [7:0] prediv_d;
    logic [1:0] rsv2;
    logic [5:0] gen_mask;
    logic [5:0] clkctl_mask;
    logic signal_absent_invert;
    logic learn;
    logic [7:0] hyst;
    logic [3:0] pfm_tc;
    logic [3:0] cfm_tc;
    logic [15:0] pfm_lim;
    logic [15:0] cfm_lim;
    logic [7:0] uncert;
    logic [7:0] max_mis;
    logic [15:0] exp_period;
  } scq_qcfg_type;
endpackage

// file: hdl/scq_qual.sv
`timescale 1ns/1ps
module scq_qual import scq_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_sample,
  input wire logic los_in,
  input wire logic lol_in,
  input wire scq_qcfg_type cfg,
  output logic [5:0] alarm,
  output logic [2:0] err_pulse,
  output logic [15:0] filt_period
);
  function automatic logic [15:0] adiff(logic [15:0] a, logic [15:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  // ==========================================================
  // Cycle monitor
  logic clk_q, scm, gst;
  logic [23:0] cnt;
  logic [15:0] ref_period;
  logic [23:0] acc [2];
  logic [1:0] fm;
  logic [8:0] gacc;
  logic [7:0] pre;
  wire rise = clk_sample & ~clk_q;
  wire fall = ~clk_sample & clk_q;
  wire [15:0] period = (|cnt[23:16]) ? 16'hffff : cnt[15:0];
  wire [24:0] mis_lim = {9'd0, ref_period} * {16'd0, 9'(cfg.max_mis) + 9'd1};
  wire mis_hit = ({1'b0, cnt} == mis_lim);
  wire ph_bad = adiff(period, ref_period) > 16'(cfg.uncert);
  wire noise_hit = rise & (period < ref_period) & ph_bad;
  wire long_hit = rise & (period > ref_period) & ph_bad;
  wire duty_hit = fall & (adiff(period, ref_period >> 1) > 16'(cfg.uncert));

  assign err_pulse = {duty_hit, noise_hit, mis_hit};

  // Period counter restarts at each rising edge; saturates so a dead input stays dead
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_q <= 1'b0;
      cnt <= 24'h00_0001;
      ref_period <= 16'h0000;
      scm <= 1'b0;
    end else begin
      clk_q <= clk_sample;
      cnt <= rise ? 24'h00_0001 : (&cnt ? cnt : cnt + 24'h00_0001);
      if (!cfg.learn) ref_period <= cfg.exp_period;
      else if (rise) ref_period <= period;
      if (mis_hit | noise_hit | duty_hit | long_hit) scm <= 1'b1;
      else if (rise) scm <= 1'b0;
    end
  end

  // ==========================================================
  // Coarse (0) and precise (1) frequency monitors
  for (genvar f = 0; f < 2; f++) begin : g_fm
    wire [4:0] sh = f ? 5'(cfg.pfm_tc) + PFM_TC_EXTRA : 5'(cfg.cfm_tc);
    wire [15:0] lim = f ? cfg.pfm_lim : cfg.cfm_lim;
    wire signed [24:0] d = $signed({1'b0, period, 8'd0}) - $signed({1'b0, acc[f]});
    wire [15:0] dev = adiff(acc[f][23:8], ref_period);
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        acc[f] <= 24'h00_0000;
        fm[f] <= 1'b0;
      end else begin
        if (rise) acc[f] <= 24'($signed({1'b0, acc[f]}) + (d >>> sh));
        // Clear only well inside the limit so a marginal input cannot chatter
        if (dev > lim) fm[f] <= 1'b1;
        else if (17'(dev) + 17'(cfg.hyst) < 17'(lim)) fm[f] <= 1'b0;
      end
    end
  end
  assign filt_period = acc[0][23:8];

  // ==========================================================
  // Guard soak integrator
  wire src = |(alarm[4:0] & cfg.gst_en);
  wire [7:0] pdiv = gst ? cfg.prediv_q : cfg.prediv_d;
  wire tick = (pre + 8'h01 >= pdiv);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre <= 8'h00;
      gacc <= 9'h000;
      gst <= 1'b0;
    end else begin
      pre <= (tick | (gst & src)) ? 8'h00 : pre + 8'h01;
      if (!gst) begin
        if (tick & src) gacc <= gacc + 9'(cfg.incr_d);
        else if (tick) gacc <= (gacc > 9'(cfg.incr_d)) ? gacc - 9'(cfg.incr_d) : 9'h000;
        if (src & (gacc >= 9'(cfg.thr_d))) begin
          gst <= 1'b1;
          gacc <= 9'h000;
        end
      end else if (src) gacc <= 9'h000;
      else if (gacc >= 9'(cfg.thr_q)) begin
        gst <= 1'b0;
        gacc <= 9'h000;
      end else if (tick) gacc <= gacc + 9'(cfg.incr_q);
    end
  end

  assign alarm = {gst, lol_in, los_in ^ cfg.signal_absent_invert, fm[1], fm[0], scm};
endmodule // scq_qual

// file: dv/scq_clk_src.sv
`timescale 1ns/1ps
// ==========================================================
// Far-side recovered clock with settable high and low lengths
module scq_clk_src (
  input wire logic aclk,
  input wire logic run,
  input wire logic [7:0] high_len,
  input wire logic [7:0] low_len,
  output logic clk_out
);
  logic [7:0] cnt;

  // A stopped source stands low, like a dead line, so missing edges are real
  always_ff @(posedge aclk) begin
    if (!run) begin
      clk_out <= 1'h0;
      cnt <= 8'h01;
    end else if (cnt >= (clk_out ? high_len : low_len)) begin
      clk_out <= ~clk_out;
      cnt <= 8'h01;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule // scq_clk_src

// file: dv/scq_top_checker.sv
`timescale 1ns/1ps
// ==========================================================
// Bus handshake and controller output checks
module scq_top_checker import scq_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] ctrl_state,
  input wire logic [31:0] freq_word
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Register bus answers and holds them until taken
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  chk_aw_blocked: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write address taken");

  // Controller state and frequency word
  chk_state_legal: assert property (ctrl_state != 2'h3)
    else $error("illegal controller state");
  // Two cycles in lock so the word has followed the state
  chk_locked_word: assert property ((ctrl_state == SCQ_ST_LOCKED) [*2] |-> freq_word[31:16] == 16'h0000)
    else $error("locked word out of range");
  chk_hold_freeze: assert property ((ctrl_state == SCQ_ST_HOLDOVER) [*3] |-> $stable(freq_word))
    else $error("holdover word moved");
endmodule // scq_top_checker

bind scq_top scq_top_checker u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .ctrl_state(ctrl_state), .freq_word(freq_word));

// file: dv/tb_sync_clock_input_qualifier.sv
`timescale 1ns/1ps
module tb_sync_clock_input_qualifier import scq_pkg::*; ;
  // ==========================================================
  // Signals, clock, sources and design
  localparam int T_DISQ = 4 * 16;
  localparam int T_QUAL = 2 * 16;
  localparam logic [31:0] CFG2_SEL = 32'h39E4_0142; // Frequency monitors left out, they settle too slowly
  logic aclk = 1'h0;
  logic aresetn, awvalid, wvalid, bready, arvalid, rready, pclk, run0, run2;
  logic awready, wready, bvalid, arready, rvalid, general_alarm;
  logic [7:0] awaddr, araddr, hi2, lo2, hl0;
  logic [31:0] wdata, rdata, freq_word;
  logic [1:0] bresp, rresp, sel, state, xg_clk;
  logic [3:0] los, lol, wstrb;
  int miscompares = 0;
  int checked = 0;

  always #2.5 aclk = ~aclk;

  // Port clock feeds qualifiers 0 and 1, xg clocks feed 2 and 3; sources start at reset release
  scq_clk_src u_src0 (.aclk(aclk), .run(run0), .high_len(hl0), .low_len(hl0), .clk_out(pclk));
  scq_clk_src u_src1 (.aclk(aclk), .run(run2), .high_len(hi2), .low_len(lo2), .clk_out(xg_clk[0]));
  scq_clk_src u_src2 (.aclk(aclk), .run(run0), .high_len(hl0), .low_len(hl0), .clk_out(xg_clk[1]));

  scq_top #(.HO_CYCLES(50)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_rec_clk({10'h000, pclk}), .diff_clk_in(2'h0), .gpio_clk_in(4'h0), .xg_rec_clk(xg_clk),
    .los_in(los), .lol_in(lol), .general_alarm(general_alarm), .selected_input(sel),
    .ctrl_state(state), .freq_word(freq_word));

  // ==========================================================
  // Reporting
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic hang;
    miscompares++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    print_verdict();
  endtask

  // ==========================================================
  // Bus and wait helpers; values are read just after the edge, before it lands
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 200);
    bready <= 1'h0;
    if (n < 200) chk(bresp, RESP_OKAY);
    if (n >= 200) hang();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 200);
    {d, r} = {rdata, rresp};
    rready <= 1'h0;
    if (n >= 200) hang();
  endtask

  task automatic wait_st(input logic [1:0] st);
    int n;
    n = 0;
    while (state !== st && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 3000) hang();
  endtask

  task automatic cnt_alarm(input logic lvl, output int n);
    n = 0;
    while (general_alarm !== lvl && n < 1000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 1000) hang();
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    logic [31:0] rst_val [6];
    rst_val = '{CFG0_RST, CFG1_RST, CFG2_RST, CFG3_RST, CFG4_RST, CTRL_RST};
    chk({state, sel}, 4'h0);
    chk(freq_word, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      rd(i < 5 ? 8'(i * 4) : OFF_CTRL, d, r);
      chk({r, d}, {RESP_OKAY, rst_val[i]});
    end
    rd(8'h18, d, r);
    chk({r, d}, {RESP_SLVERR, 32'h0000_0000});
    rd(8'h81, d, r);
    chk({r, d}, {RESP_SLVERR, 32'h0000_0000});
    $display("reset test done");
  endtask

  task automatic t_lock;
    logic [31:0] d;
    logic [1:0] r;
    for (int q = 0; q < 4; q++) begin
      wr(8'(q * 32 + 8), CFG2_SEL);
      wr(8'(q * 32 + 16), 32'h1900_0101);
    end
    wait_st(SCQ_ST_LOCKED);
    chk(sel, 2'h0);
    rd(OFF_CTRL_STAT, d, r);
    chk({d[11:8], d[3:0]}, 8'hF4);
    $display("lock test done");
  endtask

  // Integrator timing, hitless switch and revert on one qualifier
  task automatic t_gst;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    wr(8'h08, 32'h20E4_0142);
    wr(8'h0C, 32'h1002_1004);
    los[0] <= 1'h1;
    cnt_alarm(1'h1, n);
    chk(n >= T_DISQ && n <= T_DISQ + 8, 1'h1);
    chk({state, sel}, {SCQ_ST_LOCKED, 2'h1});
    rd(8'h14, d, r);
    chk({d[10:8], d[6]}, 4'hF);
    los[0] <= 1'h0;
    cnt_alarm(1'h0, n);
    chk(n >= T_QUAL && n <= T_QUAL + 8, 1'h1);
    repeat (4) @(posedge aclk);
    chk(sel, 2'h0);
    lol[0] <= 1'h1;
    repeat (4) @(posedge aclk);
    chk(sel, 2'h1);
    lol[0] <= 1'h0;
    repeat (4) @(posedge aclk);
    chk(sel, 2'h0);
    wr(8'h68, 32'h39E6_0142);
    rd(8'h74, d, r);
    chk(d[6], 1'h1);
    wr(8'h68, CFG2_SEL);
    rd(8'h74, d, r);
    chk(d[6], 1'h0);
    $display("integrator test done");
  endtask

  // Missing edges, noise and duty faults on qualifier 2
  task automatic t_scm;
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] hi_t [3];
    logic [7:0] lo_t [3];
    hi_t = '{8'h19, 8'h05, 8'h0A};
    lo_t = '{8'h19, 8'h05, 8'h28};
    for (int i = 0; i < 3; i++) begin
      @(posedge aclk);
      {hi2, lo2, run2} <= {hi_t[i], lo_t[i], i != 0};
      repeat (400) @(posedge aclk);
      rd(8'h54, d, r);
      chk(d[i], 1'h1);
      {hi2, lo2, run2} <= {8'h19, 8'h19, 1'h1};
      repeat (400) @(posedge aclk);
      wr(8'h54, 32'h0000_0007);
      rd(8'h54, d, r);
      chk(d[2:0], 3'h0);
    end
    $display("cycle monitor test done");
  endtask

  task automatic t_modes;
    logic [31:0] d;
    logic [1:0] r;
    logic [1:0] exp_st [4];
    exp_st = '{SCQ_ST_LOCKED, SCQ_ST_HOLDOVER, SCQ_ST_FREERUN, SCQ_ST_LOCKED};
    // Second write touches only the low two byte lanes
    wr(OFF_FREE_OFFSET, 32'h1234_ABCD);
    wstrb <= 4'h3;
    wr(OFF_FREE_OFFSET, 32'hFFFF_5678);
    wstrb <= 4'hF;
    for (int m = 0; m < 4; m++) begin
      wr(OFF_CTRL, {CTRL_RST[31:2], 2'(m)});
      wait_st(exp_st[m]);
      chk(state, exp_st[m]);
      if (m == 2) chk(freq_word, 32'h1234_5678);
    end
    // Holdover data needs 50 locked cycles first
    repeat (60) @(posedge aclk);
    wr(OFF_CTRL, CTRL_RST & 32'hFFFF_C3FF);
    wait_st(SCQ_ST_HOLDOVER);
    wr(OFF_CTRL, CTRL_RST);
    wait_st(SCQ_ST_LOCKED);
    // Input 0 runs at a 50-cycle period; the filter may settle one count short
    rd(OFF_FILT_FREQ, d, r);
    chk(d >= 32'd49 && d <= 32'd51 && r == RESP_OKAY, 1'h1);
    chk(freq_word >= 32'd49 && freq_word <= 32'd51, 1'h1);
    $display("mode test done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, los, lol} = '0;
    {hi2, lo2, hl0, run0, run2} = {8'h19, 8'h19, 8'h19, 2'h0};
    wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    {run0, run2} <= 2'h3;
    @(posedge aclk);
    t_reset();
    t_lock();
    t_gst();
    t_scm();
    t_modes();
    print_verdict();
  end
endmodule // tb_sync_clock_input_qualifier
